//--- sms_params.svh
// constants for the sensor measure sequencer
// assumes inclusion by bare name from the module and the testbench
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
`define SMS_ADDR_STATUS_CTRL   8'h00
`define SMS_ADDR_CTRL          8'h01
`define SMS_ADDR_SETTLE        8'h02
`define SMS_ADDR_RESULT_LO     8'h03
`define SMS_ADDR_RESULT_HI     8'h04
`define SMS_ADDR_ISD           8'h05
`define SMS_ADDR_SP            8'h06
`define SMS_BIT_FLAG           7
`define SMS_BIT_START          4
`define SMS_BIT_LOW_POWER_DIRECT_MODE           3
`define SMS_BIT_ENABLE         7
`define SMS_BIT_CAPTURE        6
`define SMS_RESET_BYTE         8'h00
`define SMS_RESET_DELAY        16'h0000
`define SMS_CE_TIME_NS         100
`define SMS_CLK_PERIOD_NS      5
`define SMS_CE_CYCLES          ((`SMS_CE_TIME_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)
`define SMS_CLR_SYNC_CYCLES    2
`endif

//--- sms_pkg.sv
// types for the sensor measure sequencer
// assumes sms_params.svh is available
package sms_pkg;
  typedef enum logic [2:0] {
    IDLE,
    SETTLE,
    TRIG,
    CONVERT,
    CLEARSYNC
  } sms_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sms_bus_t;
endpackage

//--- sms_sequencer.sv
// sensor measure sequencer: register port, settling counter, adc trigger
// assumes adc pulses conversion done; inputs synchronous to ref_clk
// Summary of operation
// - three sub-modes: automatic, direct, low power direct.
// - interface disabled and idle whenever deep stop mode is active.
// - automatic ends after one measurement; others keep running.
// - direct and low power direct keep signal chain powered continuously.
// - setting start bit begins one automatic sequence, powering transducer.
// - after automatic settling delay, pulse adc trigger.
// - after automatic conversion, clear start bit and power down.
// - start bit clears with chain off; internal sync then allows restart.
// - interface flag never asserted during automatic mode.
// - direct mode uses enable bit 7 and capture bit 6 of control.
// - direct: capture synchronised, trigger after capture-to-trigger time.
// - direct: capture bit clears itself after one full clock.
// - recapture while enabled repeats; clearing enable stops.
// - direct: clearing enable is ignored while capture is still set.
// - after enable clears, power down the chain and return to standby.
// - after each trigger, conversion complete flag is raised.
// - reading result low byte clears conversion complete.
// - standby means all control bits and settling select zero.
// - low power direct: first uses initial delay, later sample period.
// - low power direct bit going low clears capture.
`timescale 1ns/1ps
`include "sms_params.svh"
module sms_sequencer #(
  parameter int DW = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [7:0]   busAddr,
  input  wire logic [7:0]   busWdata,
  input  wire logic         busWr,
  input  wire logic         busRd,
  output logic      [7:0]   busRdata,
  input  wire logic         deepStop,
  input  wire logic         adcDone,
  input  wire logic [15:0]  adcResult,
  output logic              chainOn,
  output logic              adcTrigger,
  output logic              convComplete
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  sms_pkg::sms_state_t stateReg;
  sms_pkg::sms_bus_t   bus;
  logic            startReg;
  logic            lpdmReg;
  logic            enableReg;
  logic            captureReg;
  logic [2:0]      settleSelReg;
  logic [DW-1:0]   isdReg;
  logic [DW-1:0]   spReg;
  logic [DW-1:0]   cntReg;
  logic            lpFirstReg;
  logic [15:0]     resultReg;
  logic            cocoReg;
  logic [1:0]      clrSyncCnt;
  logic            startClearSync;
  logic            lpdmPrev;
  logic            wrSc;
  logic            wrCtrl;
  logic            capRise;
  logic            startReq;
  logic            directMode;
  logic            rdLo;
  logic [DW-1:0]   ceCycles;
  logic            convPendReg;
  // capture-to-trigger delay in cycles, for the checks
  localparam int CE_DLY = `SMS_CE_CYCLES;

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
  assign wrSc = bus.wr && (bus.addr == `SMS_ADDR_STATUS_CTRL);
  assign wrCtrl = bus.wr && (bus.addr == `SMS_ADDR_CTRL);
  assign rdLo = bus.rd && (bus.addr == `SMS_ADDR_RESULT_LO);
  assign directMode = enableReg && !lpdmReg;
  assign ceCycles = DW'(`SMS_CE_CYCLES);
  // new capture only accepted from idle
  assign capRise = wrCtrl && bus.wdata[`SMS_BIT_CAPTURE] && enableReg && !captureReg
                   && stateReg == sms_pkg::IDLE && !deepStop;
  assign startReq = wrSc && bus.wdata[`SMS_BIT_START] && !startReg && !enableReg
                    && !startClearSync && !deepStop && stateReg == sms_pkg::IDLE;
  assign startClearSync = (clrSyncCnt != 2'h0);

  // ----------------------------------------
  // control bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lpdmReg <= 1'b0;
      enableReg <= 1'b0;
      settleSelReg <= 3'h0;
      isdReg <= '0;
      spReg <= '0;
    end else if (deepStop) begin
      lpdmReg <= 1'b0;
      enableReg <= 1'b0;
      settleSelReg <= 3'h0;
    end else begin
      if (wrSc) begin
        lpdmReg <= bus.wdata[`SMS_BIT_LOW_POWER_DIRECT_MODE];
      end
      if (wrCtrl) begin
        // disable refused while a direct capture is pending
        if (bus.wdata[`SMS_BIT_ENABLE] || !captureReg || lpdmReg) begin
          enableReg <= bus.wdata[`SMS_BIT_ENABLE];
        end
        settleSelReg <= bus.wdata[2:0];
      end
      if (bus.wr && bus.addr == `SMS_ADDR_ISD) begin
        isdReg <= DW'(bus.wdata);
      end
      if (bus.wr && bus.addr == `SMS_ADDR_SP) begin
        spReg <= DW'(bus.wdata);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lpdmPrev <= 1'b0;
    end else begin
      lpdmPrev <= lpdmReg;
    end
  end

  // ----------------------------------------
  // capture bit
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      captureReg <= 1'b0;
    end else if (deepStop || (lpdmPrev && !lpdmReg)) begin
      captureReg <= 1'b0;
    end else if (capRise) begin
      captureReg <= 1'b1;
    end else if (captureReg && !lpdmReg && stateReg == sms_pkg::SETTLE) begin
      captureReg <= 1'b0;
    end
  end

  // ----------------------------------------
  // start bit and clear sync
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startReg <= 1'b0;
    end else if (deepStop || (startReg && !chainOn && stateReg == sms_pkg::CLEARSYNC)) begin
      startReg <= 1'b0;
    end else if (startReq) begin
      startReg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clrSyncCnt <= 2'h0;
    end else if (startReg && stateReg == sms_pkg::CLEARSYNC) begin
      clrSyncCnt <= 2'(`SMS_CLR_SYNC_CYCLES);
    end else if (clrSyncCnt != 2'h0) begin
      clrSyncCnt <= clrSyncCnt - 2'h1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateReg <= sms_pkg::IDLE;
      cntReg <= '0;
      lpFirstReg <= 1'b1;
    end else if (deepStop) begin
      stateReg <= sms_pkg::IDLE;
      lpFirstReg <= 1'b1;
    end else begin
      case (stateReg)
        sms_pkg::IDLE: begin
          if (!lpdmReg) begin
            lpFirstReg <= 1'b1;
          end
          if (startReq) begin
            cntReg <= isdReg;
            stateReg <= sms_pkg::SETTLE;
          end else if (capRise) begin
            cntReg <= lpdmReg ? (lpFirstReg ? isdReg : spReg) : ceCycles;
            stateReg <= sms_pkg::SETTLE;
          end
        end
        sms_pkg::SETTLE: begin
          if (cntReg <= DW'(1)) begin
            stateReg <= sms_pkg::TRIG;
          end else begin
            cntReg <= cntReg - DW'(1);
          end
        end
        sms_pkg::TRIG: begin
          lpFirstReg <= 1'b0;
          if (lpdmReg && enableReg && captureReg) begin
            cntReg <= spReg;
          end
          stateReg <= sms_pkg::CONVERT;
        end
        sms_pkg::CONVERT: begin
          if (lpdmReg && enableReg && captureReg) begin
            // period counts from the trigger cycle itself
            if (cntReg > DW'(2)) begin
              cntReg <= cntReg - DW'(1);
            end else begin
              stateReg <= sms_pkg::TRIG;
            end
            // no conversion left in flight: nothing to wait for
          end else if (adcDone || !convPendReg) begin
            stateReg <= startReg ? sms_pkg::CLEARSYNC : sms_pkg::IDLE;
          end
        end
        sms_pkg::CLEARSYNC: begin
          stateReg <= sms_pkg::IDLE;
        end
        default: begin
          stateReg <= sms_pkg::IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // conversion in flight
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      convPendReg <= 1'b0;
    end else if (adcTrigger) begin
      convPendReg <= 1'b1;
    end else if (adcDone) begin
      convPendReg <= 1'b0;
    end
  end

  // chain powered while enabled or during an automatic run
  assign chainOn = enableReg || (startReg && stateReg != sms_pkg::CLEARSYNC);
  assign adcTrigger = (stateReg == sms_pkg::TRIG);

  // ----------------------------------------
  // conversion result and flag
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cocoReg <= 1'b0;
      resultReg <= 16'h0000;
    end else if (adcDone) begin
      cocoReg <= 1'b1;
      resultReg <= adcResult;
    end else if (rdLo) begin
      cocoReg <= 1'b0;
    end
  end
  assign convComplete = cocoReg;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busRdata <= `SMS_RESET_BYTE;
    end else if (bus.rd) begin
      if (bus.addr == `SMS_ADDR_STATUS_CTRL) begin
        // flag only in direct mode, not in low power direct
        busRdata <= {directMode && cocoReg, 2'h0, startReg, lpdmReg, 3'h0};
      end else if (bus.addr == `SMS_ADDR_CTRL) begin
        busRdata <= {enableReg, captureReg, 3'h0, settleSelReg};
      end else if (bus.addr == `SMS_ADDR_SETTLE) begin
        busRdata <= {5'h00, stateReg};
      end else if (bus.addr == `SMS_ADDR_RESULT_LO) begin
        busRdata <= resultReg[7:0];
      end else if (bus.addr == `SMS_ADDR_RESULT_HI) begin
        busRdata <= resultReg[15:8];
      end else if (bus.addr == `SMS_ADDR_ISD) begin
        busRdata <= isdReg[7:0];
      end else if (bus.addr == `SMS_ADDR_SP) begin
        busRdata <= spReg[7:0];
      end else begin
        busRdata <= 8'h00;
      end
    end else begin
      busRdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  trig_one_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcTrigger |=> !adcTrigger) else $error("trigger longer than one cycle");
  deep_stop_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    deepStop |=> !enableReg && !startReg && !captureReg) else $error("active in deep stop");
  cap_self_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(captureReg) && !lpdmReg && !deepStop |=> ##1 !captureReg)
    else $error("capture did not clear");
  enable_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    captureReg && enableReg && !lpdmReg && !deepStop |=> enableReg)
    else $error("enable cleared during capture");
  conversion_complete_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcDone |=> convComplete) else $error("complete flag not set");
  conversion_complete_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdLo && !adcDone |=> !convComplete) else $error("complete flag not cleared");
  low_power_direct_mode_cap_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(lpdmReg) |=> !captureReg) else $error("capture kept after low_power_direct_mode exit");
  start_chain_a: assert property (@(posedge ref_clk) disable iff (rst)
    startReq |=> startReg && chainOn) else $error("start not taken");
  auto_trig_a: assert property (@(posedge ref_clk) disable iff (rst)
    startReq && isdReg == DW'(1) |=> ##1 adcTrigger) else $error("trigger not after delay");
  flag_auto_a: assert property (@(posedge ref_clk) disable iff (rst)
    bus.rd && bus.addr == `SMS_ADDR_STATUS_CTRL && !enableReg |=> !busRdata[7])
    else $error("flag shown in automatic mode");
  direct_trig_a: assert property (@(posedge ref_clk) disable iff (rst || deepStop)
    capRise && !lpdmReg |=> ##[CE_DLY:CE_DLY] adcTrigger) else $error("direct trigger late");
  lp_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    capRise && lpdmReg && lpFirstReg |=> cntReg == isdReg)
    else $error("first delay not initial");
  lp_repeat_a: assert property (@(posedge ref_clk) disable iff (rst || deepStop)
    stateReg == sms_pkg::CONVERT && cntReg == DW'(3) && lpdmReg && enableReg && captureReg
    && !wrSc && !wrCtrl |=> ##1 adcTrigger) else $error("sample period trigger missing");
  conv_leave_a: assert property (@(posedge ref_clk) disable iff (rst)
    stateReg == sms_pkg::CONVERT && !convPendReg && !(lpdmReg && enableReg && captureReg)
    |=> stateReg != sms_pkg::CONVERT) else $error("sequencer stuck after measurement");
  auto_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    stateReg == sms_pkg::CLEARSYNC && !enableReg |=> !startReg)
    else $error("start not cleared");
  pend_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    adcTrigger |=> convPendReg) else $error("conversion not marked in flight");
  auto_cov_c: cover property (@(posedge ref_clk) disable iff (rst)
    startReq ##[1:300] adcTrigger ##[1:300] !startReg);
  direct_cov_c: cover property (@(posedge ref_clk) disable iff (rst)
    capRise && !lpdmReg ##[1:100] adcTrigger);
  low_power_direct_mode_cov_c: cover property (@(posedge ref_clk) disable iff (rst)
    lpdmReg && adcTrigger ##[1:600] adcTrigger);
  exit_cov_c: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(lpdmReg) ##[1:20] stateReg == sms_pkg::IDLE);
endmodule

//--- sms_adc_model.sv
// converter model on the far side of the sensor measure sequencer
// assumes the trigger is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
module sms_adc_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        adcTrigger,
  input  wire logic [7:0]  latency,
  input  wire logic [15:0] value,
  output logic             adcDone,
  output logic [15:0]      adcResult
);
  logic [7:0] cntReg;
  logic       busyReg;

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busyReg   <= 1'b0;
      cntReg    <= 8'h00;
      adcDone   <= 1'b0;
      adcResult <= 16'h0000;
    end else begin
      adcDone   <= 1'b0;
      // result bus not valid outside the done pulse
      adcResult <= ~value;
      if (adcTrigger && !busyReg) begin
        busyReg <= 1'b1;
        cntReg  <= latency;
      end else if (busyReg) begin
        if (cntReg == 8'h00) begin
          busyReg   <= 1'b0;
          adcDone   <= 1'b1;
          adcResult <= value;
        end else begin
          cntReg <= cntReg - 8'h01;
        end
      end
    end
  end
endmodule

//--- tb.sv
// self-checking bench for the sensor measure sequencer
// assumes sms_adc_model as the converter and 5 ns ref_clk
`timescale 1ns/1ps
`include "sms_params.svh"
module tb;
  logic        ref_clk, rst, busWr, busRd, deepStop, adcDone;
  logic        chainOn, adcTrigger, convComplete;
  logic [7:0]  busAddr, busWdata, busRdata, lat, rdv;
  logic [15:0] adcResult;
  int          failures, tests_run;
  realtime     tTrig, t0;
  localparam logic [7:0] ROW_ADDR [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03,
                                             8'h04, 8'h05, 8'h06, 8'h07};
  localparam logic [7:0] ROW_EXP [0:7]  = '{default: 8'h00};

  sms_sequencer uut (.ref_clk(ref_clk), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .deepStop(deepStop),
    .adcDone(adcDone), .adcResult(adcResult), .chainOn(chainOn), .adcTrigger(adcTrigger),
    .convComplete(convComplete));
  sms_adc_model adc (.ref_clk(ref_clk), .rst(rst), .adcTrigger(adcTrigger),
    .latency(lat), .value(16'hA55A), .adcDone(adcDone), .adcResult(adcResult));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rng(input real c, input int lo, input int hi, input string what);
    chk({7'h00, (c >= lo && c <= hi)}, 8'h01, what);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge ref_clk);
    busWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 rdv = busRdata;
  endtask
  task automatic waitTrig();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (adcTrigger !== 1'b1 && n < 500);
    tTrig = $realtime - 1;
    chk({7'h00, adcTrigger}, 8'h01, "trigger seen");
    @(posedge ref_clk);
    #1 chk({7'h00, adcTrigger}, 8'h00, "trigger one cycle");
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    while (convComplete !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk({7'h00, convComplete}, 8'h01, "conversion complete");
  endtask
  task automatic close_out();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {busWr, busRd, deepStop} = 3'h0;
    busAddr = 8'h00;
    busWdata = 8'h00;
    lat = 8'h01;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ROW_ADDR[i]);
      chk(rdv, ROW_EXP[i], "reset value");
    end
    $display("test reset values done");
    // automatic single measurement, slow converter
    lat <= 8'h1E;
    wr(8'h05, 8'h14);
    wr(8'h00, 8'h10);
    t0 = $realtime - 6;
    chk({7'h00, chainOn}, 8'h01, "auto chain on");
    rd(8'h00);
    chk(rdv & 8'h10, 8'h10, "start reads set");
    waitTrig();
    rng((tTrig - t0) / 5, 20, 24, "auto settle");
    waitDone();
    rd(8'h00);
    chk(rdv & 8'h80, 8'h00, "no flag in auto");
    repeat (3) @(posedge ref_clk);
    #1 chk({7'h00, chainOn}, 8'h00, "auto chain off");
    rd(8'h00);
    chk(rdv & 8'h10, 8'h00, "start cleared");
    rd(8'h04);
    chk(rdv, 8'hA5, "result high");
    rd(8'h03);
    chk(rdv, 8'h5A, "result low");
    @(posedge ref_clk);
    #1 chk({7'h00, convComplete}, 8'h00, "flag cleared by low read");
    // next automatic run once start reads clear, shortest delay
    wr(8'h05, 8'h01);
    wr(8'h00, 8'h10);
    waitTrig();
    waitDone();
    rd(8'h00);
    chk(rdv & 8'h10, 8'h00, "second start cleared");
    rd(8'h03);
    $display("test automatic done");
    // direct mode
    lat <= 8'h01;
    wr(8'h01, 8'h40);
    rd(8'h01);
    chk(rdv, 8'h00, "capture refused when disabled");
    wr(8'h01, 8'h80);
    chk({7'h00, chainOn}, 8'h01, "direct chain on");
    @(posedge ref_clk);
    busWr <= 1'b1;
    busAddr <= 8'h01;
    busWdata <= 8'hC0;
    @(posedge ref_clk);
    t0 = $realtime;
    busWdata <= 8'h00;
    @(posedge ref_clk);
    busWr <= 1'b0;
    waitTrig();
    rng((tTrig - t0) / 5, `SMS_CE_CYCLES - 1, `SMS_CE_CYCLES + 3, "capture delay");
    rd(8'h01);
    chk(rdv & 8'hC0, 8'h80, "enable kept, capture self-cleared");
    waitDone();
    rd(8'h00);
    chk(rdv & 8'h80, 8'h80, "flag in direct");
    rd(8'h03);
    repeat (4) @(posedge ref_clk);
    wr(8'h01, 8'hC0);
    waitTrig();
    waitDone();
    rd(8'h03);
    wr(8'h01, 8'h00);
    chk({7'h00, chainOn}, 8'h00, "direct standby");
    rd(8'h01);
    chk(rdv, 8'h00, "control cleared");
    $display("test direct done");
    // low power direct mode
    wr(8'h05, 8'h0A);
    wr(8'h06, 8'h08);
    wr(8'h00, 8'h08);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'hC0);
    waitTrig();
    t0 = tTrig;
    waitTrig();
    rng((tTrig - t0) / 5, 8, 8, "sample period");
    chk({7'h00, chainOn}, 8'h01, "chain stays on");
    // exit: enable off first, then low power direct bit
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h01);
    chk(rdv & 8'hC0, 8'h00, "capture cleared on exit");
    rd(8'h03);
    chk({7'h00, chainOn}, 8'h00, "low power exit");
    // sequencer must be back in standby: a direct capture runs
    wr(8'h01, 8'h80);
    wr(8'h01, 8'hC0);
    waitTrig();
    $display("test low power direct done");
    // deep stop forces standby
    wr(8'h01, 8'h80);
    @(posedge ref_clk);
    deepStop <= 1'b1;
    @(posedge ref_clk);
    #1 chk({7'h00, chainOn}, 8'h00, "deep stop chain off");
    wr(8'h00, 8'h10);
    chk({7'h00, chainOn}, 8'h00, "start refused in deep stop");
    rd(8'h01);
    chk(rdv, 8'h00, "deep stop standby");
    deepStop <= 1'b0;
    $display("test deep stop done");
    close_out();
  end
endmodule
